// [core/qscm_top.sv]
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - sixteen eight-bit command entries sit as one contiguous block, entry bit 0 being the msb.
// - with the hold flag clear, the select pins go back to the general-purpose value after the transfer.
// - with the hold flag set, the select outputs stay asserted after the transfer.
// - the width flag picks eight bits when clear and the serial_control_0 width field when set.
// - the post-transfer delay flag picks 17 system clocks when clear and the serial_control_1 count when set.
// - the select-to-clock flag picks half an sck period when clear and the seven-bit count when set.
// - the four select bits drive four select outputs for the transfer, in any combination.
// - the lowest select shares its pin with the slave select input used in slave mode.
// - slave select driven low while working as master raises a mode fault.
// - seven pins belong to the serial port and serve as general-purpose pins when not needed.
// - each pin's direction follows its bit of the pin direction register.
module qscm_top (
    // system clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // link clock
    input wire logic link_clk,
    // serial port pins
    input wire logic [qscm_pkg::NUM_PINS-1:0] qs_pin_in,
    output logic [qscm_pkg::NUM_PINS-1:0] qs_pin_out,
    output logic [qscm_pkg::NUM_PINS-1:0] qs_pin_oe_n
);
    import qscm_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    typedef enum logic [1:0] {S_IDLE, S_CFG, S_XFER, S_POST} qscm_st_t;
    qscm_st_t st_reg;

    qscm_link_if lk ();

    logic dp_wr_reg;
    logic [31:0] dp_addr_reg;
    logic [31:0] rd_next;

    logic [7:0] cmd_mem [NUM_ENTRIES];
    logic [15:0] tx_mem [NUM_ENTRIES];
    logic [15:0] rx_mem [NUM_ENTRIES];

    logic run_reg, master_reg, ena_reg;
    logic [3:0] end_idx_reg;
    logic [3:0] width_reg;
    logic [7:0] dtl_reg;
    logic [6:0] dsckl_reg;
    logic [6:0] dir_reg;
    logic [6:0] gpio_reg;
    logic done_reg, fault_reg;
    logic cfg_dirty_reg;

    logic [3:0] idx_reg;
    logic [7:0] cur_cmd_reg;
    logic [8:0] dly_reg;

    logic req_reg;
    qscm_req_t kind_reg;
    logic [4:0] nbits_reg;
    logic [15:0] pl_tx_reg;
    logic [6:0] pl_gpio_reg, pl_dir_reg, pl_dsckl_reg;
    logic pl_en_reg;

    logic ak_s1, ak_s2, ak_s3, ak_seen;
    logic [6:0] pin_s1, pin_s2, pin_s3, pin_lvl;

    logic wr_cmd, wr_tx, wr_ctrl, wr_sc0, wr_sc1, wr_dir, wr_gpio, wr_stat;
    logic [3:0] wr_idx;
    logic ack_evt, rx_cap, fault_set, start_ok, last_ent;
    logic [4:0] nbits_next;
    logic [8:0] dly_next;

    // ----------------------------------------
    // ahb-lite slave
    // ----------------------------------------

    // zero wait state: read data is looked up in the address phase and registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= 32'h0000_0000;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0; // always okay
            dp_wr_reg <= hsel && htrans[1] && hready && hwrite;
            dp_addr_reg <= haddr;
            if (hsel && htrans[1] && hready && !hwrite) hrdata <= rd_next;
        end
    end

    // read decode; unmapped words read as zero
    always_comb begin
        rd_next = 32'h0000_0000;
        if (haddr[31:6] == ADDR_CMD[31:6]) begin
            rd_next[7:0] = cmd_mem[haddr[5:2]];
        end else if (haddr[31:6] == ADDR_TX[31:6]) begin
            rd_next[15:0] = tx_mem[haddr[5:2]];
        end else if (haddr[31:6] == ADDR_RX[31:6]) begin
            rd_next[15:0] = rx_mem[haddr[5:2]];
        end else if (haddr[31:2] == ADDR_CTRL[31:2]) begin
            rd_next[CTRL_RUN_BIT] = run_reg;
            rd_next[CTRL_MASTER_BIT] = master_reg;
            rd_next[CTRL_ENA_BIT] = ena_reg;
            rd_next[CTRL_END_LSB +: 4] = end_idx_reg;
        end else if (haddr[31:2] == ADDR_SC0[31:2]) begin
            rd_next[SC0_WIDTH_LSB +: 4] = width_reg;
        end else if (haddr[31:2] == ADDR_SC1[31:2]) begin
            rd_next[SC1_DSCKL_LSB +: 7] = dsckl_reg;
            rd_next[SC1_DTL_LSB +: 8] = dtl_reg;
        end else if (haddr[31:2] == ADDR_DIR[31:2]) begin
            rd_next[6:0] = dir_reg;
        end else if (haddr[31:2] == ADDR_GPIO[31:2]) begin
            rd_next[6:0] = gpio_reg;
        end else if (haddr[31:2] == ADDR_STAT[31:2]) begin
            rd_next[STAT_DONE_BIT] = done_reg;
            rd_next[STAT_FAULT_BIT] = fault_reg;
            rd_next[STAT_BUSY_BIT] = (st_reg != S_IDLE) || run_reg;
            rd_next[STAT_SS_BIT] = pin_lvl[PIN_SEL_LSB];
            rd_next[STAT_IDX_LSB +: 4] = idx_reg;
        end else if (haddr[31:2] == ADDR_PINS[31:2]) begin
            rd_next[6:0] = pin_lvl;
        end
    end

    // write decode in the data phase
    assign wr_idx = dp_addr_reg[5:2];
    assign wr_cmd = dp_wr_reg && (dp_addr_reg[31:6] == ADDR_CMD[31:6]);
    assign wr_tx = dp_wr_reg && (dp_addr_reg[31:6] == ADDR_TX[31:6]);
    assign wr_ctrl = dp_wr_reg && (dp_addr_reg[31:2] == ADDR_CTRL[31:2]);
    assign wr_sc0 = dp_wr_reg && (dp_addr_reg[31:2] == ADDR_SC0[31:2]);
    assign wr_sc1 = dp_wr_reg && (dp_addr_reg[31:2] == ADDR_SC1[31:2]);
    assign wr_dir = dp_wr_reg && (dp_addr_reg[31:2] == ADDR_DIR[31:2]);
    assign wr_gpio = dp_wr_reg && (dp_addr_reg[31:2] == ADDR_GPIO[31:2]);
    assign wr_stat = dp_wr_reg && (dp_addr_reg[31:2] == ADDR_STAT[31:2]);

    // ----------------------------------------
    // entry storage
    // ----------------------------------------

    // one command, transmit and receive word per queue position
    for (genvar i = 0; i < NUM_ENTRIES; i++) begin : g_ent
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cmd_mem[i] <= CMD_RST;
                tx_mem[i] <= DATA_RST;
                rx_mem[i] <= DATA_RST;
            end else begin
                if (wr_cmd && wr_idx == 4'(i)) cmd_mem[i] <= hwdata[7:0];
                if (wr_tx && wr_idx == 4'(i)) tx_mem[i] <= hwdata[15:0];
                if (rx_cap && idx_reg == 4'(i)) rx_mem[i] <= lk.rx_data;
            end
        end
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------

    // software setup; run is also cleared by the sequencer at queue end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_reg <= 1'b0;
            master_reg <= 1'b0;
            ena_reg <= 1'b0;
            end_idx_reg <= 4'h0;
            width_reg <= 4'h0;
            dtl_reg <= 8'h00;
            dsckl_reg <= 7'h00;
            dir_reg <= PIN_RST;
            gpio_reg <= PIN_RST;
        end else begin
            if (wr_ctrl) begin
                run_reg <= hwdata[CTRL_RUN_BIT];
                master_reg <= hwdata[CTRL_MASTER_BIT];
                ena_reg <= hwdata[CTRL_ENA_BIT];
                end_idx_reg <= hwdata[CTRL_END_LSB +: 4];
            end else if (st_reg == S_POST && dly_reg == 9'h001 && (last_ent || fault_reg)) begin
                run_reg <= 1'b0;
            end
            if (wr_sc0) width_reg <= hwdata[SC0_WIDTH_LSB +: 4];
            if (wr_sc1) dtl_reg <= hwdata[SC1_DTL_LSB +: 8];
            if (wr_sc1) dsckl_reg <= hwdata[SC1_DSCKL_LSB +: 7];
            if (wr_dir) dir_reg <= hwdata[6:0];
            if (wr_gpio) gpio_reg <= hwdata[6:0];
        end
    end

    // ----------------------------------------
    // pin sampling and mode fault
    // ----------------------------------------

    // three-flop synchronisers; a change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= PIN_RST;
            pin_s2 <= PIN_RST;
            pin_s3 <= PIN_RST;
            pin_lvl <= 7'h7f;
            {ak_s1, ak_s2, ak_s3, ak_seen} <= 4'h0;
        end else begin
            pin_s1 <= qs_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_lvl <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_lvl & (pin_s2 ^ pin_s3));
            {ak_s1, ak_s2, ak_s3} <= {lk.ack_tgl, ak_s1, ak_s2};
            if (ack_evt) ak_seen <= ak_s3;
        end
    end

    assign ack_evt = (ak_s2 == ak_s3) && (ak_s3 != ak_seen);

    // the shared select pin is only an input when its direction bit is clear
    assign fault_set = ena_reg && master_reg && !dir_reg[PIN_SEL_LSB] && !pin_lvl[PIN_SEL_LSB];

    // sticky status; write one clears, a new event in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            if (st_reg == S_POST && dly_reg == 9'h001 && (last_ent || fault_reg)) done_reg <= 1'b1;
            else if (wr_stat && hwdata[STAT_DONE_BIT]) done_reg <= 1'b0;
            if (fault_set) fault_reg <= 1'b1;
            else if (wr_stat && hwdata[STAT_FAULT_BIT]) fault_reg <= 1'b0;
        end
    end

    // pin setup must reach the link side before a transfer may use it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_dirty_reg <= 1'b1;
        end else begin
            if (wr_dir || wr_gpio || wr_ctrl) cfg_dirty_reg <= 1'b1;
            else if (st_reg == S_IDLE) cfg_dirty_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // queue sequencer
    // ----------------------------------------

    assign start_ok = run_reg && master_reg && ena_reg && !fault_reg;
    assign last_ent = (idx_reg == end_idx_reg);
    assign rx_cap = (st_reg == S_XFER) && ack_evt;

    // transfer length from the entry's width flag
    always_comb begin
        nbits_next = DEF_NBITS;
        if (cmd_mem[idx_reg][CMD_WSEL_BIT]) nbits_next = (width_reg == 4'h0) ? 5'h10 : {1'b0, width_reg};
    end

    // post-transfer gap in system clocks; a zero count means 256
    always_comb begin
        dly_next = POST_DLY_CYC;
        if (cur_cmd_reg[CMD_DT_BIT]) dly_next = (dtl_reg == 8'h00) ? 9'h100 : {1'b0, dtl_reg};
    end

    // payload is held steady from the toggle until the answering toggle returns
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_reg <= S_IDLE;
            idx_reg <= 4'h0;
            cur_cmd_reg <= CMD_RST;
            dly_reg <= 9'h000;
            req_reg <= 1'b0;
            kind_reg <= QSCM_REQ_CFG;
            nbits_reg <= DEF_NBITS;
            pl_tx_reg <= DATA_RST;
            pl_gpio_reg <= PIN_RST;
            pl_dir_reg <= PIN_RST;
            pl_dsckl_reg <= 7'h00;
            pl_en_reg <= 1'b0;
        end else begin
            case (st_reg)
                S_IDLE: begin
                    if (cfg_dirty_reg) begin
                        kind_reg <= QSCM_REQ_CFG;
                        pl_gpio_reg <= gpio_reg;
                        pl_dir_reg <= dir_reg;
                        pl_en_reg <= ena_reg && master_reg;
                        req_reg <= ~req_reg;
                        st_reg <= S_CFG;
                    end else if (start_ok) begin
                        kind_reg <= QSCM_REQ_XFER;
                        cur_cmd_reg <= cmd_mem[idx_reg];
                        nbits_reg <= nbits_next;
                        pl_tx_reg <= tx_mem[idx_reg];
                        pl_dsckl_reg <= dsckl_reg;
                        req_reg <= ~req_reg;
                        st_reg <= S_XFER;
                    end else if (!run_reg) begin
                        idx_reg <= 4'h0;
                    end
                end
                S_CFG: begin
                    if (ack_evt) st_reg <= S_IDLE;
                end
                S_XFER: begin
                    if (ack_evt) begin
                        dly_reg <= dly_next;
                        st_reg <= S_POST;
                    end
                end
                S_POST: begin
                    dly_reg <= dly_reg - 9'h001;
                    if (dly_reg == 9'h001) begin
                        idx_reg <= (last_ent || fault_reg) ? 4'h0 : idx_reg + 4'h1;
                        st_reg <= S_IDLE;
                    end
                end
                default: st_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // link side
    // ----------------------------------------

    assign lk.req_tgl = req_reg;
    assign lk.req_kind = kind_reg;
    assign lk.cmd = cur_cmd_reg;
    assign lk.nbits = nbits_reg;
    assign lk.dsckl = pl_dsckl_reg;
    assign lk.tx_data = pl_tx_reg;
    assign lk.gpio = pl_gpio_reg;
    assign lk.dir = pl_dir_reg;
    assign lk.ser_en = pl_en_reg;

    // serial engine and pin flops on the link clock
    qscm_link u_link (
        .link_clk(link_clk),
        .hresetn(hresetn),
        .lk(lk.eng),
        .pin_in(qs_pin_in),
        .pin_out(qs_pin_out),
        .pin_oe_n(qs_pin_oe_n)
    );

endmodule

// [core/qscm_pkg.sv]
package qscm_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int NUM_ENTRIES = 16;
    localparam int NUM_PINS = 7;
    // ----------------------------------------
    // byte addresses
    // ----------------------------------------
    localparam logic [31:0] ADDR_CMD = 32'h0030_51c0;
    localparam logic [31:0] ADDR_TX = 32'h0030_5200;
    localparam logic [31:0] ADDR_RX = 32'h0030_5240;
    localparam logic [31:0] ADDR_CTRL = 32'h0030_5280;
    localparam logic [31:0] ADDR_SC0 = 32'h0030_5284;
    localparam logic [31:0] ADDR_SC1 = 32'h0030_5288;
    localparam logic [31:0] ADDR_DIR = 32'h0030_528c;
    localparam logic [31:0] ADDR_GPIO = 32'h0030_5290;
    localparam logic [31:0] ADDR_STAT = 32'h0030_5294;
    localparam logic [31:0] ADDR_PINS = 32'h0030_5298;
    // ----------------------------------------
    // field positions (entry bit 0 is hdl bit 7)
    // ----------------------------------------
    localparam int CMD_HOLD_BIT = 7;
    localparam int CMD_WSEL_BIT = 6;
    localparam int CMD_DT_BIT = 5;
    localparam int CMD_SELECT_TO_CLOCK_DELAY_SELECT_BIT = 4;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MASTER_BIT = 1;
    localparam int CTRL_ENA_BIT = 2;
    localparam int CTRL_END_LSB = 8;
    localparam int SC0_WIDTH_LSB = 0;
    localparam int SC1_DSCKL_LSB = 0;
    localparam int SC1_DTL_LSB = 8;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_SS_BIT = 3;
    localparam int STAT_IDX_LSB = 8;
    localparam int PIN_MISO = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_SCK = 2;
    localparam int PIN_SEL_LSB = 3;
    // ----------------------------------------
    // reset values and counts
    // ----------------------------------------
    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [15:0] DATA_RST = 16'h0000;
    localparam logic [6:0] PIN_RST = 7'h00;
    localparam logic [4:0] DEF_NBITS = 5'h08;
    localparam int SYS_CLK_MHZ = 125;
    localparam int POST_DLY_PERIODS = 17;
    localparam logic [8:0] POST_DLY_CYC = 9'(POST_DLY_PERIODS * (SYS_CLK_MHZ / SYS_CLK_MHZ));
    typedef enum logic {QSCM_REQ_CFG, QSCM_REQ_XFER} qscm_req_t;
endpackage

// [core/qscm_link_if.sv]
`timescale 1ns/1ps
interface qscm_link_if;
    import qscm_pkg::*;
    logic req_tgl;
    qscm_req_t req_kind;
    logic [7:0] cmd;
    logic [4:0] nbits;
    logic [6:0] dsckl;
    logic [15:0] tx_data;
    logic [6:0] gpio;
    logic [6:0] dir;
    logic ser_en;
    logic ack_tgl;
    logic [15:0] rx_data;
    modport seq (output req_tgl, req_kind, cmd, nbits, dsckl, tx_data, gpio, dir, ser_en,
                 input ack_tgl, rx_data);
    modport eng (input req_tgl, req_kind, cmd, nbits, dsckl, tx_data, gpio, dir, ser_en,
                 output ack_tgl, rx_data);
endinterface

// [core/qscm_link.sv]
`timescale 1ns/1ps
module qscm_link (
    // link clock and reset
    input wire logic link_clk,
    input wire logic hresetn,
    // sequencer side
    qscm_link_if.eng lk,
    // serial port pins
    input wire logic [qscm_pkg::NUM_PINS-1:0] pin_in,
    output logic [qscm_pkg::NUM_PINS-1:0] pin_out,
    output logic [qscm_pkg::NUM_PINS-1:0] pin_oe_n
);
    import qscm_pkg::*;
    typedef enum logic [1:0] {L_IDLE, L_LEAD, L_SHIFT, L_TAIL} qscm_lst_t;
    qscm_lst_t st_reg;
    logic rst_s1, rst_n, rq_s1, rq_s2, rq_s3, rq_seen, mi_s1, mi_s2, mi_s3, mi_lvl;
    logic sck_reg, own_reg, en_reg, ack_reg;
    logic [7:0] cmd_reg, cnt_reg;
    logic [4:0] bit_reg, rxp_reg;
    logic [15:0] sh_reg, rx_reg;
    logic [6:0] gpio_reg, dir_reg;
    wire rq_new = (rq_s2 == rq_s3) && (rq_s3 != rq_seen);
    assign lk.ack_tgl = ack_reg;
    assign lk.rx_data = rx_reg;
    // reset release synchronised to the link clock, assertion stays asynchronous
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) {rst_n, rst_s1} <= 2'b00;
        else {rst_n, rst_s1} <= {rst_s1, 1'b1};
    end
    // three-flop synchronisers; a change counts once stages two and three agree
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            {rq_s1, rq_s2, rq_s3, rq_seen} <= 4'h0;
            {mi_s1, mi_s2, mi_s3, mi_lvl} <= 4'h0;
        end else begin
            {rq_s1, rq_s2, rq_s3} <= {lk.req_tgl, rq_s1, rq_s2};
            {mi_s1, mi_s2, mi_s3} <= {pin_in[PIN_MISO], mi_s1, mi_s2};
            if (rq_new) rq_seen <= rq_s3;
            if (mi_s2 == mi_s3) mi_lvl <= mi_s3;
        end
    end
    // serial engine: sck is link_clk / 2, idle low, data sampled on the rising edge
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= L_IDLE;
            {sck_reg, own_reg, en_reg, ack_reg} <= 4'h0;
            {cmd_reg, cnt_reg, bit_reg, rxp_reg} <= 26'h0;
            {sh_reg, rx_reg} <= {DATA_RST, DATA_RST};
            {gpio_reg, dir_reg} <= {PIN_RST, PIN_RST};
        end else begin
            case (st_reg)
                L_IDLE: begin
                    if (rq_new && lk.req_kind == QSCM_REQ_CFG) begin
                        {gpio_reg, dir_reg, en_reg} <= {lk.gpio, lk.dir, lk.ser_en};
                        if (!lk.ser_en) own_reg <= 1'b0;
                        ack_reg <= ~ack_reg;
                    end else if (rq_new) begin
                        cmd_reg <= lk.cmd;
                        bit_reg <= lk.nbits;
                        sh_reg <= lk.tx_data << (5'd16 - lk.nbits);
                        rx_reg <= DATA_RST;
                        own_reg <= 1'b1;
                        if (!lk.cmd[CMD_SELECT_TO_CLOCK_DELAY_SELECT_BIT]) cnt_reg <= 8'h01;
                        else cnt_reg <= (lk.dsckl == 7'h00) ? 8'h80 : {1'b0, lk.dsckl};
                        st_reg <= L_LEAD;
                    end
                end
                L_LEAD: begin
                    if (cnt_reg == 8'h01) st_reg <= L_SHIFT;
                    else cnt_reg <= cnt_reg - 8'h01;
                end
                L_SHIFT: begin
                    sck_reg <= ~sck_reg;
                    if (sck_reg) begin
                        sh_reg <= {sh_reg[14:0], 1'b0};
                        bit_reg <= bit_reg - 5'h01;
                        if (bit_reg == 5'h01) st_reg <= L_TAIL;
                    end
                end
                L_TAIL: begin
                    if (rxp_reg == 5'h00) begin
                        own_reg <= cmd_reg[CMD_HOLD_BIT];
                        ack_reg <= ~ack_reg;
                        st_reg <= L_IDLE;
                    end
                end
                default: st_reg <= L_IDLE;
            endcase
            // sck-rise samples wait out the five-clock miso synchroniser lag
            rxp_reg <= {rxp_reg[3:0], st_reg == L_SHIFT && !sck_reg};
            if (rxp_reg[4]) rx_reg <= {rx_reg[14:0], mi_lvl};
        end
    end
    // pin ownership: serial function or general-purpose value, direction from software
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= PIN_RST;
            pin_oe_n <= 7'h7f;
        end else begin
            pin_out[PIN_MISO] <= gpio_reg[PIN_MISO];
            pin_out[PIN_MOSI] <= en_reg ? sh_reg[15] : gpio_reg[PIN_MOSI];
            pin_out[PIN_SCK] <= en_reg ? sck_reg : gpio_reg[PIN_SCK];
            pin_out[6:3] <= own_reg ? cmd_reg[3:0] : gpio_reg[6:3];
            pin_oe_n <= ~dir_reg;
        end
    end
endmodule

// [dv/qscm_properties.sv]
`timescale 1ns/1ps
module qscm_properties (
    // bus side
    input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [1:0] htrans,
    input wire logic [31:0] haddr, hwdata, hrdata,
    // pin side
    input wire logic link_clk,
    input wire logic [6:0] qs_pin_out, qs_pin_oe_n
);
    import qscm_pkg::*;
    logic take, bad_q, dir_q, dw;
    logic [6:0] dv;
    assign take = hsel && htrans[1] && hready;
    // remember address phases, the data phase is judged one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {bad_q, dir_q, dw, dv} <= '0;
        end else begin
            bad_q <= take && !hwrite && !(haddr inside {[ADDR_CMD:ADDR_PINS]});
            dir_q <= take && hwrite && haddr == ADDR_DIR;
            dw <= dir_q;
            if (dir_q) dv <= hwdata[6:0];
        end
    end
    // the push into the link domain needs a few link clocks, so allow a window
    sequence dir_lands;
        ##[0:200] (qs_pin_oe_n == ~dv);
    endsequence
    okay_resp_a: assert property (@(posedge hclk) disable iff (!hresetn) !hresp)
        else $error("response not okay");
    ready_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(hresetn) |-> hreadyout) else $error("hreadyout low");
    bad_addr_a: assert property (@(posedge hclk) disable iff (!hresetn)
        bad_q |-> hrdata == 32'h0) else $error("unmapped read not zero");
    rdata_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite) |=> $stable(hrdata)) else $error("hrdata moved without a read");
    dir_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dw |-> dir_lands) else $error("pin enables do not follow direction");
    rst_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(hresetn) |-> qs_pin_oe_n == 7'h7f ##1 hreadyout) else $error("bad state after reset");
    sck_pulse_a: assert property (@(posedge link_clk) disable iff (!hresetn)
        $rose(qs_pin_out[PIN_SCK]) |=> $fell(qs_pin_out[PIN_SCK])) else $error("sck high too long");
    mosi_setup_a: assert property (@(posedge link_clk) disable iff (!hresetn)
        $rose(qs_pin_out[PIN_SCK]) |-> $stable(qs_pin_out[PIN_MOSI])) else $error("mosi moved at sck rise");
endmodule
bind qscm_top qscm_properties i_props (.*);

// [dv/qscm_periph.sv]
`timescale 1ns/1ps
module qscm_periph #(parameter logic [7:0] REPLY = 8'ha5) (
    // wires seen by the peripheral
    input wire logic sel,
    input wire logic sck,
    output logic miso
);
    logic [7:0] sh = 8'h00;
    // load on select, next bit on falling sck; a released line shows the inverse of its last bit
    always @(posedge sel) sh = REPLY;
    always @(negedge sck) if (sel) sh = {sh[6:0], ~sh[7]};
    assign miso = sel ? sh[7] : ~sh[7];
endmodule

// [dv/qscm_top_test.sv]
`timescale 1ns/1ps
module qscm_top_test;
    import qscm_pkg::*;
    logic hclk = 0, link_clk = 0, hresetn = 0, hsel = 0, hwrite = 0, ss_low = 0, miso;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, mosi_sh;
    logic hreadyout, hresp;
    logic [3:0] sel_seen;
    logic [6:0] pin_out, pin_oe_n, pin_in;
    int failures = 0, n_tests = 0, sck_n = 0;
    // link clock runs at a tenth of hclk, offset so its edges never meet an hclk edge
    initial forever #4 hclk = ~hclk;
    initial begin #3; forever #40 link_clk = ~link_clk; end
    // released pins sit at the pull-up except pin 0, which carries miso; pin 3 can be pulled low to fake a slave select
    assign pin_in = (pin_out & ~pin_oe_n) | ({3'h7, !ss_low, 2'h3, miso} & pin_oe_n);
    always @(posedge pin_in[PIN_SCK]) begin
        sck_n++;
        mosi_sh = {mosi_sh[30:0], pin_in[PIN_MOSI]};
        sel_seen = pin_in[6:3];
    end
    qscm_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .qs_pin_in(pin_in),
        .qs_pin_out(pin_out), .qs_pin_oe_n(pin_oe_n));
    qscm_periph i_peer (.sel(pin_in[PIN_SEL_LSB+1]), .sck(pin_in[PIN_SCK]), .miso(miso));
    task automatic give_verdict;
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for hready at a rising edge
    task automatic hwait;
        int n;
        n = 0;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin failures++; give_verdict; end
    endtask
    // one single transfer, an idle cycle ahead so a read never follows its own write
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        hwait;
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        hwait;
        rd = hrdata;
    endtask
    task automatic wait_flag(input int b);
        int n;
        rd = 0;
        for (n = 0; n < 400 && rd[b] !== 1'b1; n++) bus(0, ADDR_STAT, 0);
        chk("status flag", 32'h1, {31'h0, rd[b]});
        if (n >= 400) give_verdict;
        bus(1, ADDR_STAT, 32'h1 << b);
    endtask
    task automatic t_regs;
        bus(0, ADDR_CMD + 32'h3c, 0);
        chk("last entry reset", 0, rd);
        for (int i = 0; i < 16; i++) bus(1, ADDR_CMD + 32'(4 * i), 32'h100 | 32'(i * 17));
        for (int i = 0; i < 16; i++) begin
            bus(0, ADDR_CMD + 32'(4 * i), 0);
            chk("entry", 32'(i * 17), rd);
        end
        bus(1, 32'h0030_5300, 32'h5a);
        bus(0, 32'h0030_5300, 0);
        chk("unmapped", 0, rd);
        $display("register test done");
    endtask
    task automatic t_xfer(input logic [7:0] cmd, input logic [31:0] nb, rxe, txe, sel_after);
        bus(1, ADDR_CMD, {24'h0, cmd});
        bus(1, ADDR_TX, 32'ha5c3);
        sck_n = 0;
        bus(1, ADDR_CTRL, 32'h7);
        wait_flag(STAT_DONE_BIT);
        chk("sck pulses", nb, 32'(sck_n));
        chk("mosi bits", txe, mosi_sh & ((32'h1 << nb) - 1));
        chk("selects during", {28'h0, cmd[3:0]}, {28'h0, sel_seen});
        chk("selects after", sel_after, {25'h0, pin_in[6:3]});
        bus(0, ADDR_RX, 0);
        chk("rx word", rxe, rd);
        $display("transfer test done");
    endtask
    task automatic t_fault;
        bus(1, ADDR_DIR, 32'h76);
        ss_low <= 1;
        bus(1, ADDR_CTRL, 32'h7);
        wait_flag(STAT_FAULT_BIT);
        ss_low <= 0;
        $display("fault test done");
    endtask
    initial begin
        repeat (3) @(posedge link_clk);
        @(posedge hclk) hresetn <= 1;
        repeat (12) @(posedge link_clk);
        t_regs;
        bus(1, ADDR_DIR, 32'h7e);
        bus(1, ADDR_GPIO, 0);
        bus(1, ADDR_SC0, 32'hc);
        bus(1, ADDR_SC1, 32'h0403);
        t_xfer(8'h0a, 8, 32'ha5, 32'hc3, 0);
        t_xfer(8'hfa, 12, 32'ha55, 32'h5c3, 32'ha);
        t_fault;
        give_verdict;
    end
endmodule
